//--- inc/ee_guard_consts.svh
// Offsets, field positions, unlock key bytes and timing counts for the EEPROM write guard.
// Assumes a 200 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef EE_GUARD_CONSTS_SVH
`define EE_GUARD_CONSTS_SVH

// Register indices as printed; byte address is four times the index
`define IDX_CELL_VALUE      8'h9a
`define IDX_CELL_INDEX      8'h9b
`define IDX_EEPROM_CONTROL  8'h9c
`define IDX_UNLOCK_KEY      8'h9d
`define IDX_IRQ_STATUS      8'ha0
`define IDX_IRQ_MASK        8'ha1
`define IDX_GUARD_STATUS    8'ha2

// Control register fields
`define CTL_READ_START      0
`define CTL_WRITE_START     1
`define CTL_UPDATE_PERMIT   2
`define CTL_ABORTED         3
`define CTL_DONE            4

// Interrupt status fields
`define IRQ_DONE            0
`define IRQ_ABORTED         1

// Unlock key bytes
`define KEY_FIRST           8'h55
`define KEY_SECOND          8'haa

// Clock and timing
`define CLK_PERIOD_NS       5
`define HOLD_TIME_MS        72
`define HOLD_CYCLES         ((`HOLD_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define WRITE_TIME_US       4
`define WRITE_CYCLES        ((`WRITE_TIME_US * 1000) / `CLK_PERIOD_NS)
`define KEY_GAP_CYCLES      64

// AXI responses
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

//--- inc/ee_guard_pkg.sv
// Types shared by the EEPROM write guard design.
// Assumes the constants header is included alongside.
package ee_guard_pkg;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_ARMED
  } key_state_type;

endpackage

//--- hw/ee_cell_array.sv
// Storage array of 128 data bytes with a synchronous read port and a write port.
// Assumes one clock; reads return on the cycle after the strobe.
`timescale 1ns/10ps
module ee_cell_array (
  input  wire logic       clk,
  input  wire logic       rd_en,
  input  wire logic       wr_en,
  input  wire logic [6:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  logic [7:0] cells [0:127];

  // Contents survive every reset, as nonvolatile storage would
  always_ff @(posedge clk) begin
    if (wr_en) begin
      cells[addr] <= wdata;
    end
    if (rd_en) begin
      rdata <= cells[addr];
    end
  end

endmodule

//--- hw/ee_write_guard.sv
// Register front end, unlock sequencer and write timer for a 128-byte data EEPROM.
// Assumes an AXI4-Lite master on clk; por_n_pin and warm_reset_pin come from outside.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "ee_guard_consts.svh"
module ee_write_guard #(
  parameter int unsigned HOLD_CYCLES_P  = `HOLD_CYCLES,
  parameter int unsigned WRITE_CYCLES_P = `WRITE_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        por_n_pin,
  input  wire logic        warm_reset_pin,
  input  wire logic        code_protect,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq_q
);

  // Pin synchronisers: first stage read only by the second
  // The protection strap is a pin too, so it gets the same two stages
  logic [1:0] por_sync_q;
  logic [1:0] warm_sync_q;
  logic [1:0] prot_sync_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      por_sync_q  <= 2'h0;
      warm_sync_q <= 2'h0;
      prot_sync_q <= 2'h0;
    end else begin
      por_sync_q  <= {por_sync_q[0], por_n_pin};
      warm_sync_q <= {warm_sync_q[0], warm_reset_pin};
      prot_sync_q <= {prot_sync_q[0], code_protect};
    end
  end
  wire por_active  = !por_sync_q[1];
  wire warm_active = warm_sync_q[1];

  // Register state
  logic [7:0]  cell_value_q;
  logic [6:0]  cell_index_q;
  logic        index_top_q;
  logic        permit_q;
  logic        write_busy_q;
  logic        aborted_q;
  logic        done_q;
  logic [1:0]  irq_status_q;
  logic [1:0]  irq_mask_q;
  logic [31:0] hold_cnt_q;
  logic [31:0] write_cnt_q;
  logic [7:0]  key_gap_q;
  logic        read_pending_q;
  ee_guard_pkg::key_state_type key_state_q;

  // AXI write channel capture: address and data taken in either order
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_idx_q;
  logic [7:0]  w_data_q;
  logic        w_lane0_q;

  // Write decode, declared ahead of the capture logic that clears on it
  wire wr_fire = aw_held_q && w_held_q && !s_axi_bvalid;
  wire wr_ok   = wr_fire && w_lane0_q;
  wire wr_map  = (aw_idx_q == `IDX_CELL_VALUE) || (aw_idx_q == `IDX_CELL_INDEX) ||
                 (aw_idx_q == `IDX_EEPROM_CONTROL) || (aw_idx_q == `IDX_UNLOCK_KEY) ||
                 (aw_idx_q == `IDX_IRQ_STATUS) || (aw_idx_q == `IDX_IRQ_MASK) ||
                 (aw_idx_q == `IDX_GUARD_STATUS);
  wire wr_ctl  = wr_ok && (aw_idx_q == `IDX_EEPROM_CONTROL);
  wire wr_key  = wr_ok && (aw_idx_q == `IDX_UNLOCK_KEY);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_data_q  <= 8'h00;
      w_lane0_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr[9:2];
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q  <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end
  // Ready only while the matching holder is empty, so nothing is dropped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Power-on hold timer: counts down after the power-on pin releases
  always_ff @(posedge clk) begin
    if (!nrst || por_active) begin
      hold_cnt_q <= HOLD_CYCLES_P;
    end else if (hold_cnt_q != 32'h0000_0000) begin
      hold_cnt_q <= hold_cnt_q - 32'h0000_0001;
    end
  end
  wire hold_running = (hold_cnt_q != 32'h0000_0000);

  // Unlock sequencer: 55h then AAh then write start, each inside a short gap
  // The gap limit stands in for exact instruction timing; a stray write aborts it
  wire any_other_wr = wr_ok && !wr_key && !wr_ctl;
  wire key_expired  = (key_gap_q == 8'(`KEY_GAP_CYCLES));
  always_ff @(posedge clk) begin
    if (!nrst || por_active || warm_active) begin
      key_state_q <= ee_guard_pkg::KEY_IDLE;
      key_gap_q   <= 8'h00;
    end else begin
      key_gap_q <= (key_state_q == ee_guard_pkg::KEY_IDLE || wr_ok) ? 8'h00 :
                   (key_expired ? key_gap_q : key_gap_q + 8'h01);
      case (key_state_q)
        ee_guard_pkg::KEY_IDLE: begin
          if (wr_key && w_data_q == `KEY_FIRST) begin
            key_state_q <= ee_guard_pkg::KEY_GOT_FIRST;
          end
        end
        ee_guard_pkg::KEY_GOT_FIRST: begin
          if (wr_key && w_data_q == `KEY_SECOND) begin
            key_state_q <= ee_guard_pkg::KEY_ARMED;
          end else if (wr_ok || key_expired) begin
            key_state_q <= ee_guard_pkg::KEY_IDLE;
          end
        end
        ee_guard_pkg::KEY_ARMED: begin
          if (wr_ok || key_expired || any_other_wr) begin
            key_state_q <= ee_guard_pkg::KEY_IDLE; // one try per unlock
          end
        end
        default: begin
          key_state_q <= ee_guard_pkg::KEY_IDLE;
        end
      endcase
    end
  end

  // Write start qualification
  wire start_req  = wr_ctl && w_data_q[`CTL_WRITE_START];
  wire write_go   = start_req && !write_busy_q && permit_q && !hold_running &&
                    (key_state_q == ee_guard_pkg::KEY_ARMED);
  wire write_done = write_busy_q && (write_cnt_q == 32'h0000_0001);

  // Write timer holds the start bit until it expires; a warm reset aborts it
  always_ff @(posedge clk) begin
    if (!nrst || por_active) begin
      write_busy_q <= 1'b0;
      write_cnt_q  <= 32'h0000_0000;
    end else if (warm_active) begin
      write_busy_q <= 1'b0;
      write_cnt_q  <= 32'h0000_0000;
    end else if (write_go) begin
      write_busy_q <= 1'b1;
      write_cnt_q  <= WRITE_CYCLES_P;
    end else if (write_busy_q) begin
      write_cnt_q  <= write_cnt_q - 32'h0000_0001;
      if (write_done) begin
        write_busy_q <= 1'b0;
      end
    end
  end

  // Permit bit: cleared at power-up and by warm reset, software sets and clears it
  always_ff @(posedge clk) begin
    if (!nrst || por_active || warm_active) begin
      permit_q <= 1'b0;
    end else if (wr_ctl) begin
      permit_q <= w_data_q[`CTL_UPDATE_PERMIT];
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle
  wire abort_evt = warm_active && write_busy_q;
  always_ff @(posedge clk) begin
    if (!nrst || por_active) begin
      aborted_q <= 1'b0;
      done_q    <= 1'b0;
    end else begin
      if (abort_evt) begin
        aborted_q <= 1'b1;
      end else if (wr_ctl && !w_data_q[`CTL_ABORTED]) begin
        aborted_q <= 1'b0;
      end
      if (write_done) begin
        done_q <= 1'b1;
      end else if (wr_ctl && !w_data_q[`CTL_DONE]) begin
        done_q <= 1'b0;
      end
    end
  end

  // Interrupt status, write one to clear, set wins
  always_ff @(posedge clk) begin
    if (!nrst || por_active) begin
      irq_status_q <= 2'b00;
      irq_mask_q   <= 2'b00;
    end else begin
      if (wr_ok && aw_idx_q == `IDX_IRQ_MASK) begin
        irq_mask_q <= w_data_q[1:0];
      end
      irq_status_q[`IRQ_DONE]    <= write_done ||
        (irq_status_q[`IRQ_DONE] &&
         !(wr_ok && aw_idx_q == `IDX_IRQ_STATUS && w_data_q[`IRQ_DONE]));
      irq_status_q[`IRQ_ABORTED] <= abort_evt ||
        (irq_status_q[`IRQ_ABORTED] &&
         !(wr_ok && aw_idx_q == `IDX_IRQ_STATUS && w_data_q[`IRQ_ABORTED]));
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // Read start: strobe the array now, data lands in the value register two cycles later
  wire read_go = wr_ctl && w_data_q[`CTL_READ_START] && !write_busy_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      read_pending_q <= 1'b0;
    end else begin
      read_pending_q <= read_go;
    end
  end

  // Address and data survive warm resets; code protection does not gate CPU access
  logic [7:0] array_rdata;
  always_ff @(posedge clk) begin
    if (!nrst || por_active) begin
      cell_value_q <= 8'h00;
      cell_index_q <= 7'h00;
      index_top_q  <= 1'b0;
    end else begin
      if (read_pending_q) begin
        cell_value_q <= array_rdata;
      end else if (wr_ok && aw_idx_q == `IDX_CELL_VALUE && !write_busy_q) begin
        cell_value_q <= w_data_q;
      end
      if (wr_ok && aw_idx_q == `IDX_CELL_INDEX && !write_busy_q) begin
        cell_index_q <= w_data_q[6:0];
        index_top_q  <= w_data_q[7];
      end
    end
  end

  // Data passes through unscrambled whatever the protection strap says
  ee_cell_array u_cells (
    .clk   (clk),
    .rd_en (read_go),
    .wr_en (write_go && !index_top_q),
    .addr  (cell_index_q),
    .wdata (cell_value_q),
    .rdata (array_rdata)
  );
  wire unused_protect = prot_sync_q[1]; // Status only, never gates access

  // Read channel: one-cycle answer, key port reads zero
  logic [7:0] rd_byte;
  logic       rd_hit;
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    case (s_axi_araddr[9:2])
      `IDX_CELL_VALUE:     rd_byte = cell_value_q;
      `IDX_CELL_INDEX:     rd_byte = {index_top_q, cell_index_q};
      `IDX_EEPROM_CONTROL: rd_byte = {3'b000, done_q, aborted_q, permit_q,
                                      write_busy_q, 1'b0};
      `IDX_UNLOCK_KEY:     rd_byte = 8'h00;
      `IDX_IRQ_STATUS:     rd_byte = {6'b00_0000, irq_status_q};
      `IDX_IRQ_MASK:       rd_byte = {6'b00_0000, irq_mask_q};
      `IDX_GUARD_STATUS:   rd_byte = {5'b0_0000, unused_protect, key_state_q != 
                                      ee_guard_pkg::KEY_IDLE, hold_running};
      default:             rd_hit  = 1'b0;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else if (s_axi_rvalid) begin
      s_axi_arready <= 1'b0;
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_byte};
      s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

//--- testbench/ee_guard_assertions.sv
// Bus-level checks for the EEPROM write guard.
// Assumes it is bound onto ee_write_guard and sees only its ports.
`timescale 1ns/10ps
`include "ee_guard_consts.svh"
module ee_guard_assertions (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        irq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Address and data taken at one edge, response a bounded time later
  sequence both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_answer;
    ##[1:3] s_axi_bvalid;
  endsequence

  a_write_answer: assert property (both_taken |-> b_answer)
    else $error("write response late");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read accepted");
  a_aw_drops: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_resp_legal: assert property (s_axi_bvalid |->
    s_axi_bresp == `RESP_OKAY || s_axi_bresp == `RESP_SLVERR)
    else $error("illegal write response");
  // Reset must silence the bus and the interrupt within one cycle
  a_reset_quiet: assert property (disable iff (1'b0)
    !nrst |=> !s_axi_bvalid && !s_axi_rvalid && !irq_q)
    else $error("outputs active in reset");
  a_ready_release: assert property ($rose(nrst) |=> s_axi_arready && s_axi_awready)
    else $error("ready missing after reset");
endmodule
bind ee_write_guard ee_guard_assertions chk_u (.clk, .nrst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_q);

//--- testbench/testbench.sv
// Self-checking bench for the EEPROM write guard over AXI4-Lite.
// Assumes short hold and write counts; responses are checked from queues.
`timescale 1ns/10ps
`include "ee_guard_consts.svh"
module testbench;
  logic        clk, nrst, por_n, warm, cp, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, irq;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [1:0]  bresp, rresp;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];
  logic [33:0] e_r;
  logic [15:0] seed_q;
  logic [7:0]  d;
  int          errors, checks;

  ee_write_guard #(.HOLD_CYCLES_P(50), .WRITE_CYCLES_P(10)) dut_u (
    .clk(clk), .nrst(nrst), .por_n_pin(por_n), .warm_reset_pin(warm), .code_protect(cp),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .irq_q(irq));

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Write: both channels offered together, each released once taken
  task automatic wr(input logic [7:0] i, input logic [7:0] v, input logic [1:0] r = `RESP_OKAY);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= {22'h0, i, 2'h0};
    wdata <= {24'h0, v};
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'h0;
      if (wrdy) wv <= 1'h0;
    end while (!bv);
    br <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] v, input logic [1:0] r = `RESP_OKAY);
    rq.push_back({r, 24'h0, v});
    @(posedge clk);
    araddr <= {22'h0, i, 2'h0};
    arv <= 1'h1;
    rr <= 1'h1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'h0;
    end while (!rv);
    rr <= 1'h0;
  endtask

  // Permit, both key bytes, then the control write that may start
  task automatic arm(input logic [7:0] p, input logic [7:0] k2, input logic [7:0] c);
    wr(`IDX_EEPROM_CONTROL, p);
    wr(`IDX_UNLOCK_KEY, `KEY_FIRST);
    wr(`IDX_UNLOCK_KEY, k2);
    wr(`IDX_EEPROM_CONTROL, c);
  endtask

  // Response watcher: oldest note is compared with each answer
  always @(posedge clk) begin
    if (rv && rr) begin
      e_r = rq.pop_front();
      check("rresp", {30'h0, e_r[33:32]}, {30'h0, rresp});
      if (e_r[33:32] == `RESP_OKAY) check("rdata", e_r[31:0], rdata);
    end
    if (bv && br) check("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
  end

  // Watchdog: the whole run needs well under a thousand cycles; the limit is 8000
  initial begin
    #40000;
    errors++;
    give_verdict();
  end

  initial begin
    {nrst, por_n, warm, cp, awv, wv, br, arv, rr} = '0;
    {awaddr, wdata, araddr} = '0;
    seed_q = 16'ha420;
    @(posedge clk);
    por_n <= 1'h1;
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    rd(`IDX_EEPROM_CONTROL, 8'h00);
    rd(`IDX_GUARD_STATUS, 8'h01);
    arm(8'h04, `KEY_SECOND, 8'h06);
    rd(`IDX_EEPROM_CONTROL, 8'h04);
    repeat (70) @(posedge clk);
    // Broken sequences: no permit, wrong second key, a write slipped in
    for (int k = 0; k < 3; k++) begin
      wr(`IDX_EEPROM_CONTROL, k == 0 ? 8'h00 : 8'h04);
      wr(`IDX_UNLOCK_KEY, `KEY_FIRST);
      wr(`IDX_UNLOCK_KEY, k == 1 ? 8'h5a : `KEY_SECOND);
      if (k == 2) wr(`IDX_CELL_INDEX, 8'h01);
      wr(`IDX_EEPROM_CONTROL, k == 0 ? 8'h02 : 8'h06);
      rd(`IDX_EEPROM_CONTROL, k == 0 ? 8'h00 : 8'h04);
      repeat (70) @(posedge clk);
    end
    // Good writes with and without code protection, then read back
    for (int k = 0; k < 2; k++) begin
      cp <= k[0];
      seed_q = lfsr(seed_q);
      d = seed_q[15:8];
      wr(`IDX_IRQ_MASK, k == 0 ? 8'h01 : 8'h00);
      wr(`IDX_CELL_INDEX, {1'h0, seed_q[6:0]});
      wr(`IDX_CELL_VALUE, d);
      arm(8'h04, `KEY_SECOND, 8'h06);
      rd(`IDX_EEPROM_CONTROL, 8'h06);
      repeat (12) @(posedge clk);
      rd(`IDX_EEPROM_CONTROL, 8'h14);
      rd(`IDX_IRQ_STATUS, 8'h01);
      check("irq", {31'h0, k == 0}, {31'h0, irq});
      wr(`IDX_IRQ_STATUS, 8'h01);
      repeat (3) @(posedge clk);
      check("irq", 32'h0, {31'h0, irq});
      wr(`IDX_CELL_VALUE, ~d);
      wr(`IDX_EEPROM_CONTROL, 8'h01);
      rd(`IDX_CELL_VALUE, d);
      rd(`IDX_GUARD_STATUS, {5'h00, k[0], 2'h0});
    end
    rd(8'h50, 8'h00, `RESP_SLVERR);
    wr(8'h50, 8'h00, `RESP_SLVERR);
    // Warm reset in mid-write
    wr(`IDX_CELL_INDEX, 8'h05);
    wr(`IDX_CELL_VALUE, 8'h3c);
    arm(8'h04, `KEY_SECOND, 8'h06);
    warm <= 1'h1;
    repeat (6) @(posedge clk);
    warm <= 1'h0;
    repeat (6) @(posedge clk);
    rd(`IDX_EEPROM_CONTROL, 8'h08);
    rd(`IDX_CELL_INDEX, 8'h05);
    rd(`IDX_CELL_VALUE, 8'h3c);
    rd(`IDX_IRQ_STATUS, 8'h02);
    wr(`IDX_UNLOCK_KEY, `KEY_FIRST);
    rd(`IDX_UNLOCK_KEY, 8'h00);
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule
